// ---- common/axo_pkg.sv ----
// constants, register map and field layout of the axis origin search and wiring check block
// Function
// - pulse rate numerator and denominator 1..100000, default 1, reject ratio above one
// - max motor speed 1..32767 rpm, default 3000, maps to full-scale 10 V reference
// - soft limits default to +/-39999999; span must contain zero for origin search
// - unlimited feed mode ignores soft limits and wraps present position inside them
// - power-on origin mode takes the position at power-up as origin, no motion
// - reverse mode turns the motor around on a limit seen before proximity
// - one-direction mode raises an error on a limit seen before proximity
// - phase Z detection direction selectable, positive by default
// - search starts same as or opposite to phase Z direction, same by default
// - high-to-low switch from proximity input, or limit input used as proximity
// - on a limit during search stop by draining error counter or by deceleration
// - proximity input polarity normally open or normally closed, default open
// - at first servo lock emit test pulses one way and check feedback count
// - wiring check timeout 0..99 steps of 10 ms, default 10, i.e. 100 ms
// - test pulse count 0..999, default 50
// - absolute correction added to absolute encoder reading on absolute origin setting
// - normal mode positions only after origin is set and within soft limits
// - search at high speed until proximity, then low speed until phase Z
package axo_pkg;
  // register byte offsets
  localparam logic [7:0] A_RATE_NUM = 8'h00, A_RATE_DEN = 8'h04, A_MAX_RPM = 8'h08;
  localparam logic [7:0] A_SLIM_POS = 8'h0C, A_SLIM_NEG = 8'h10, A_CFG = 8'h14;
  localparam logic [7:0] A_WCHK_TIME = 8'h18, A_WCHK_PULSES = 8'h1C, A_ABS_CORR = 8'h20;
  localparam logic [7:0] A_SRCH_HI = 8'h24, A_SRCH_LO = 8'h28, A_CTRL = 8'h2C;
  localparam logic [7:0] A_STATUS = 8'h30, A_POSITION = 8'h34, A_WCHK_COUNT = 8'h38;
  // ranges and reset values
  localparam logic [31:0] RATE_MIN = 32'h0000_0001, RATE_MAX = 32'h0001_86A0;
  localparam logic [31:0] RPM_MAX = 32'h0000_7FFF, WCHK_TIME_MAX = 32'h0000_0063;
  localparam logic [31:0] WCHK_PULSES_MAX = 32'h0000_03E7;
  localparam logic [16:0] RST_RATE = 17'h0_0001;
  localparam logic [14:0] RST_MAX_RPM = 15'h0BB8, RST_SRCH_HI = 15'h012C;
  localparam logic [14:0] RST_SRCH_LO = 15'h001E, FS_CODE = 15'h7FFF;
  localparam logic signed [31:0] RST_SLIM_POS = 32'sh0262_59FF;
  localparam logic signed [31:0] RST_SLIM_NEG = -32'sh0262_59FF;
  localparam logic [6:0] RST_WCHK_TIME = 7'h0A;
  localparam logic [9:0] RST_WCHK_PULSES = 10'h032;
  localparam logic [9:0] RST_CFG = 10'h100;
  // configuration fields
  localparam int B_UNLIM = 0, B_OMODE = 1, B_ZNEG = 3, B_START_OPP = 4, B_DEC_LIM = 5;
  localparam int B_STOP_DEC = 6, B_PROX_NC = 7, B_WCHK_EN = 8, B_ABS = 9;
  localparam logic [1:0] OM_POWER_ON = 2'h0, OM_REVERSE = 2'h1, OM_ONE_DIR = 2'h2;
  // control and status fields
  localparam int C_START = 0, C_CLR = 1;
  localparam int ST_BUSY = 0, ST_ORIGIN = 1, ST_LIM_ERR = 2, ST_WCHK_ERR = 3;
  localparam int ST_WCHK_DONE = 4, ST_CFG_ERR = 5, ST_SOFT_LIM = 6, ST_MOVE_OK = 7;
  // timing
  localparam int CLK_HZ = 50_000_000;
  localparam int STEP_MS = 10;
  localparam int CYC_STEP = CLK_HZ / 1000 * STEP_MS;
  localparam logic [3:0] TP_GAP_CYC = 4'hF;
  localparam logic [14:0] DECEL_STEP = 15'h0040;
  localparam logic TP_DIR_POS = 1'b0;
endpackage

// ---- design/axo_axis.sv ----
// per-axis parameter registers, origin search sequencer and wiring check
//
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/10ps
module axo_axis #(
  parameter int unsigned P_CYC_STEP = axo_pkg::CYC_STEP
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // sensor and feedback inputs
  input wire logic i_lim_pos,
  input wire logic i_lim_neg,
  input wire logic i_prox,
  input wire logic i_phase_z,
  input wire logic i_fb_inc,
  input wire logic i_fb_dec,
  input wire logic i_servo_lock,
  input wire logic [31:0] i_abs_pos,
  // drive outputs
  output logic signed [15:0] o_speed_ref,
  output logic o_drain,
  output logic o_tp_pulse,
  output logic o_tp_dir,
  // state outputs
  output logic o_origin_done,
  output logic o_move_ok,
  output logic o_search_busy
);

  typedef enum logic [1:0] {S_IDLE, S_HIGH, S_STOP, S_LOW} axo_srch_t;
  typedef enum logic [1:0] {W_IDLE, W_EMIT, W_WAIT} axo_wchk_t;
  localparam int SW = $clog2(P_CYC_STEP + 1);

  logic [16:0] rate_num, rate_den;
  logic [14:0] max_rpm, srch_hi, srch_lo, mag, tgt;
  logic signed [31:0] slim_pos, slim_neg, pos, abs_corr;
  logic [9:0] cfg, wchk_pulses, tp_sent;
  logic [6:0] wchk_time, wchk_ticks;
  logic [SW-1:0] step_cnt;
  logic [3:0] gap_cnt;
  logic signed [11:0] fb_cnt;
  logic origin, lim_err, wchk_err, wchk_done, cfg_err, por_done, lock_d, wchk_used;
  logic dir, abort;
  axo_srch_t state;
  axo_wchk_t wst;

  ////////////////////////////////////////////////////////////////////////////
  // write decode and candidate checks
  logic wr_num, wr_den, wr_rpm, wr_ctrl, rate_ok, rate_wr, span_ok, soft_lim, start;
  logic [16:0] num_c, den_c;
  logic in_rate;
  assign wr_num = i_wr && i_addr == axo_pkg::A_RATE_NUM;
  assign wr_den = i_wr && i_addr == axo_pkg::A_RATE_DEN;
  assign wr_rpm = i_wr && i_addr == axo_pkg::A_MAX_RPM;
  assign wr_ctrl = i_wr && i_addr == axo_pkg::A_CTRL;
  assign rate_wr = wr_num || wr_den;
  assign in_rate = i_wdata >= axo_pkg::RATE_MIN && i_wdata <= axo_pkg::RATE_MAX;
  assign num_c = wr_num ? i_wdata[16:0] : rate_num;
  assign den_c = wr_den ? i_wdata[16:0] : rate_den;
  assign rate_ok = in_rate && num_c <= den_c;
  assign span_ok = slim_neg <= 32'sh0 && slim_pos >= 32'sh0;
  assign start = wr_ctrl && i_wdata[axo_pkg::C_START] && state == S_IDLE;

  ////////////////////////////////////////////////////////////////////////////
  // pulse rate pair, written only as an accepted pair
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      rate_num <= axo_pkg::RST_RATE;
      rate_den <= axo_pkg::RST_RATE;
    end else if (rate_wr && rate_ok) begin
      rate_num <= num_c;
      rate_den <= den_c;
    end
  end

  // maximum speed and search speeds
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      max_rpm <= axo_pkg::RST_MAX_RPM;
      srch_hi <= axo_pkg::RST_SRCH_HI;
      srch_lo <= axo_pkg::RST_SRCH_LO;
    end else if (i_wr) begin
      if (wr_rpm && i_wdata >= 32'h1 && i_wdata <= axo_pkg::RPM_MAX)
        max_rpm <= i_wdata[14:0];
      if (i_addr == axo_pkg::A_SRCH_HI && i_wdata <= axo_pkg::RPM_MAX)
        srch_hi <= i_wdata[14:0];
      if (i_addr == axo_pkg::A_SRCH_LO && i_wdata <= axo_pkg::RPM_MAX)
        srch_lo <= i_wdata[14:0];
    end
  end

  // limits, mode word, wiring check settings, absolute correction
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      slim_pos <= axo_pkg::RST_SLIM_POS;
      slim_neg <= axo_pkg::RST_SLIM_NEG;
      cfg <= axo_pkg::RST_CFG;
      wchk_time <= axo_pkg::RST_WCHK_TIME;
      wchk_pulses <= axo_pkg::RST_WCHK_PULSES;
      abs_corr <= 32'sh0;
    end else if (i_wr) begin
      case (i_addr)
        axo_pkg::A_SLIM_POS: slim_pos <= i_wdata;
        axo_pkg::A_SLIM_NEG: slim_neg <= i_wdata;
        axo_pkg::A_CFG: cfg <= i_wdata[9:0];
        axo_pkg::A_ABS_CORR: abs_corr <= i_wdata;
        axo_pkg::A_WCHK_TIME: begin
          if (i_wdata <= axo_pkg::WCHK_TIME_MAX)
            wchk_time <= i_wdata[6:0];
        end
        axo_pkg::A_WCHK_PULSES: begin
          if (i_wdata <= axo_pkg::WCHK_PULSES_MAX)
            wchk_pulses <= i_wdata[9:0];
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sensor decode for the search
  logic prox_act, lim_fwd, decel_trig, org_evt, rej;
  logic [29:0] prod;
  logic [14:0] rpm_sel;
  assign prox_act = i_prox ^ cfg[axo_pkg::B_PROX_NC];
  assign lim_fwd = dir ? i_lim_neg : i_lim_pos;
  assign decel_trig = cfg[axo_pkg::B_DEC_LIM] ? lim_fwd : prox_act;
  assign org_evt = (state == S_LOW && i_phase_z) ||
    (start && cfg[2:1] == axo_pkg::OM_POWER_ON) ||
    (!por_done && cfg[2:1] == axo_pkg::OM_POWER_ON);
  // search speed scaled so max_rpm gives full-scale 10 V
  assign rpm_sel = state == S_LOW ? srch_lo : srch_hi;
  assign prod = 30'(rpm_sel > max_rpm ? max_rpm : rpm_sel) * 30'(axo_pkg::FS_CODE);
  assign tgt = 15'(prod / 30'(max_rpm));

  // config error flag: set wins over clear
  assign rej = (rate_wr && !rate_ok) ||
    (wr_rpm && (i_wdata < 32'h1 || i_wdata > axo_pkg::RPM_MAX)) ||
    (start && cfg[2:1] != axo_pkg::OM_POWER_ON && !span_ok);
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst)
      cfg_err <= 1'b0;
    else if (rej)
      cfg_err <= 1'b1;
    else if (wr_ctrl && i_wdata[axo_pkg::C_CLR])
      cfg_err <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // origin search sequencer
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= S_IDLE;
      dir <= 1'b0;
      abort <= 1'b0;
      lim_err <= 1'b0;
    end else begin
      if (wr_ctrl && i_wdata[axo_pkg::C_CLR])
        lim_err <= 1'b0;
      case (state)
        S_IDLE: begin
          if (start && cfg[2:1] != axo_pkg::OM_POWER_ON && span_ok) begin
            dir <= cfg[axo_pkg::B_ZNEG] ^ cfg[axo_pkg::B_START_OPP];
            abort <= 1'b0;
            state <= S_HIGH;
          end
        end
        S_HIGH: begin
          if (decel_trig) begin
            dir <= cfg[axo_pkg::B_ZNEG];
            state <= S_LOW;
          end else if (lim_fwd) begin
            if (cfg[2:1] != axo_pkg::OM_REVERSE) begin
              abort <= 1'b1;
              lim_err <= 1'b1;
            end
            state <= S_STOP;
          end
        end
        S_STOP: begin
          if (mag == 15'h0) begin
            if (abort)
              state <= S_IDLE;
            else begin
              dir <= ~dir;
              state <= S_HIGH;
            end
          end
        end
        S_LOW: begin
          if (i_phase_z)
            state <= S_IDLE;
          else if (lim_fwd) begin
            abort <= 1'b1;
            lim_err <= 1'b1;
            state <= S_STOP;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // speed magnitude: drain stops at once, deceleration ramps down
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      mag <= 15'h0;
      o_drain <= 1'b0;
    end else begin
      o_drain <= 1'b0;
      case (state)
        S_HIGH, S_LOW: mag <= tgt;
        S_STOP: begin
          if (!cfg[axo_pkg::B_STOP_DEC]) begin
            mag <= 15'h0;
            o_drain <= mag != 15'h0;
          end else
            mag <= mag > axo_pkg::DECEL_STEP ? mag - axo_pkg::DECEL_STEP : 15'h0;
        end
        default: mag <= 15'h0;
      endcase
    end
  end

  // signed speed reference, positive direction is a positive code
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst)
      o_speed_ref <= 16'sh0;
    else
      o_speed_ref <= dir ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
  end

  ////////////////////////////////////////////////////////////////////////////
  // origin flag and present position
  logic signed [31:0] pos_inc, pos_dec;
  logic unlim;
  assign unlim = cfg[axo_pkg::B_UNLIM];
  assign pos_inc = pos + 32'sh1;
  assign pos_dec = pos - 32'sh1;
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      pos <= 32'sh0;
      origin <= 1'b0;
      por_done <= 1'b0;
    end else begin
      por_done <= 1'b1;
      if (start)
        origin <= 1'b0;
      if (org_evt) begin
        origin <= 1'b1;
        pos <= cfg[axo_pkg::B_ABS] ? i_abs_pos + abs_corr : 32'sh0;
      end else if (i_fb_inc && !i_fb_dec) begin
        pos <= (unlim && pos_inc >= slim_pos) ? slim_neg : pos_inc;
      end else if (i_fb_dec && !i_fb_inc) begin
        pos <= (unlim && pos_dec < slim_neg) ? slim_pos - 32'sh1 : pos_dec;
      end
    end
  end

  // positioning permission
  assign soft_lim = !unlim && (pos > slim_pos || pos < slim_neg);
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst)
      o_move_ok <= 1'b0;
    else
      o_move_ok <= unlim || (origin && !soft_lim && state == S_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // wiring check at first servo lock
  logic lock_rise, step_end;
  assign lock_rise = i_servo_lock && !lock_d;
  assign step_end = step_cnt == SW'(P_CYC_STEP - 1);
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      wst <= W_IDLE;
      lock_d <= 1'b0;
      wchk_used <= 1'b0;
      wchk_done <= 1'b0;
      wchk_err <= 1'b0;
      tp_sent <= 10'h0;
      gap_cnt <= 4'h0;
      step_cnt <= '0;
      wchk_ticks <= 7'h0;
      fb_cnt <= 12'sh0;
      o_tp_pulse <= 1'b0;
    end else begin
      lock_d <= i_servo_lock;
      o_tp_pulse <= 1'b0;
      if (wr_ctrl && i_wdata[axo_pkg::C_CLR])
        wchk_err <= 1'b0;
      if (wst != W_IDLE) begin
        if (i_fb_inc && !i_fb_dec)
          fb_cnt <= fb_cnt + 12'sh1;
        else if (i_fb_dec && !i_fb_inc)
          fb_cnt <= fb_cnt - 12'sh1;
      end
      case (wst)
        W_IDLE: begin
          if (lock_rise && !wchk_used) begin
            wchk_used <= 1'b1;
            if (cfg[axo_pkg::B_WCHK_EN]) begin
              wst <= W_EMIT;
              tp_sent <= 10'h0;
              gap_cnt <= 4'h0;
              fb_cnt <= 12'sh0;
            end
          end
        end
        W_EMIT: begin
          gap_cnt <= gap_cnt + 4'h1;
          if (tp_sent == wchk_pulses) begin
            wst <= W_WAIT;
            step_cnt <= '0;
            wchk_ticks <= 7'h0;
          end else if (gap_cnt == axo_pkg::TP_GAP_CYC) begin
            o_tp_pulse <= 1'b1;
            tp_sent <= tp_sent + 10'h1;
          end
        end
        W_WAIT: begin
          step_cnt <= step_end ? '0 : step_cnt + SW'(1);
          if (step_end)
            wchk_ticks <= wchk_ticks + 7'h1;
          if (fb_cnt == $signed({2'b00, wchk_pulses}) || wchk_ticks >= wchk_time) begin
            wst <= W_IDLE;
            wchk_done <= 1'b1;
            if (fb_cnt != $signed({2'b00, wchk_pulses}))
              wchk_err <= 1'b1;
          end
        end
        default: wst <= W_IDLE;
      endcase
    end
  end
  assign o_tp_dir = axo_pkg::TP_DIR_POS;

  ////////////////////////////////////////////////////////////////////////////
  // state outputs and read port
  assign o_origin_done = origin;
  assign o_search_busy = state != S_IDLE;
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst)
      o_rdata <= 32'h0;
    else if (i_rd) begin
      case (i_addr)
        axo_pkg::A_RATE_NUM: o_rdata <= {15'h0, rate_num};
        axo_pkg::A_RATE_DEN: o_rdata <= {15'h0, rate_den};
        axo_pkg::A_MAX_RPM: o_rdata <= {17'h0, max_rpm};
        axo_pkg::A_SLIM_POS: o_rdata <= slim_pos;
        axo_pkg::A_SLIM_NEG: o_rdata <= slim_neg;
        axo_pkg::A_CFG: o_rdata <= {22'h0, cfg};
        axo_pkg::A_WCHK_TIME: o_rdata <= {25'h0, wchk_time};
        axo_pkg::A_WCHK_PULSES: o_rdata <= {22'h0, wchk_pulses};
        axo_pkg::A_ABS_CORR: o_rdata <= abs_corr;
        axo_pkg::A_SRCH_HI: o_rdata <= {17'h0, srch_hi};
        axo_pkg::A_SRCH_LO: o_rdata <= {17'h0, srch_lo};
        axo_pkg::A_STATUS: o_rdata <= {24'h0, o_move_ok, soft_lim, cfg_err,
          wchk_done, wchk_err, lim_err, origin, o_search_busy};
        axo_pkg::A_POSITION: o_rdata <= pos;
        axo_pkg::A_WCHK_COUNT: o_rdata <= {{20{fb_cnt[11]}}, fb_cnt};
        default: o_rdata <= 32'h0;
      endcase
    end else
      o_rdata <= 32'h0;
  end

endmodule

// ---- tb/axo_axis_sva.sv ----
// assertion checker for the axis origin search and wiring check block
`timescale 1ns/10ps
module axo_axis_chk (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  // drive and state outputs
  input wire logic signed [15:0] o_speed_ref,
  input wire logic o_drain,
  input wire logic o_tp_pulse,
  input wire logic o_tp_dir,
  input wire logic o_origin_done,
  input wire logic o_search_busy
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);
  // register read slot and wiring check pulses
  chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data not zero outside its slot");
  chk_tp_dir: assert property (o_tp_dir == axo_pkg::TP_DIR_POS)
    else $error("test pulse direction not positive");
  chk_tp_gap: assert property (o_tp_pulse |=> (!o_tp_pulse) [*8])
    else $error("test pulses too close");
  // origin search sequencing
  chk_drain_one: assert property (o_drain |=> !o_drain)
    else $error("drain request longer than one cycle");
  chk_drain_zero: assert property (o_drain |=> o_speed_ref == 16'sh0)
    else $error("speed reference not zero after drain");
  chk_busy_excl: assert property (!(o_search_busy && o_origin_done))
    else $error("origin set while searching");
  chk_start_cause: assert property ($rose(o_search_busy) |->
    ($past(i_wr) && $past(i_addr) == axo_pkg::A_CTRL) ||
    ($past(i_wr, 2) && $past(i_addr, 2) == axo_pkg::A_CTRL))
    else $error("search started without a control write");
  chk_busy_speed: assert property ($rose(o_search_busy) |-> ##[1:3] o_speed_ref != 16'sh0)
    else $error("search started without speed");
  chk_speed_idle: assert property ((!o_search_busy) [*3] |-> o_speed_ref == 16'sh0)
    else $error("speed reference while idle");
  chk_speed_clip: assert property (o_speed_ref >= -16'sh7FFF)
    else $error("speed reference beyond full scale");
  // main scenarios
  cov_search: cover property ($rose(o_search_busy));
  cov_drain: cover property (o_drain);
  cov_pulse: cover property (o_tp_pulse);
endmodule
bind axo_axis axo_axis_chk axo_axis_chk_i (.i_core_clk, .i_rst, .i_addr, .i_wdata, .i_wr,
  .i_rd, .o_rdata, .o_speed_ref, .o_drain, .o_tp_pulse, .o_tp_dir, .o_origin_done,
  .o_search_busy);

// ---- tb/axo_drive_model.sv ----
// servo driver and encoder stand-in that echoes test pulses as feedback
`timescale 1ns/10ps
module axo_drive_model (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // test pulse from the axis and fault choice
  input wire logic i_tp_pulse,
  input wire logic i_tp_dir,
  input wire logic i_flip,
  // encoder feedback
  output logic o_fb_inc,
  output logic o_fb_dec
);
  logic [2:0] dly;
  logic dir;
  // three-cycle echo, wrong way round when a fault is asked for
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      dly <= 3'h0;
      dir <= 1'b0;
    end else begin
      dly <= {dly[1:0], i_tp_pulse};
      if (i_tp_pulse) dir <= i_tp_dir ^ i_flip;
    end
  end
  assign o_fb_inc = dly[2] && !dir;
  assign o_fb_dec = dly[2] && dir;
endmodule

// ---- tb/tb_axo_axis.sv ----
// self-checking bench for the axis origin search and wiring check block
`timescale 1ns/10ps
module tb_axo_axis;
  logic i_core_clk, i_rst, i_wr, i_rd, i_lim_pos, i_lim_neg, i_prox, i_phase_z;
  logic i_fb_inc, i_fb_dec, i_servo_lock, flip, o_drain, o_tp_pulse, o_tp_dir;
  logic o_origin_done, o_move_ok, o_search_busy;
  logic [7:0] i_addr;
  logic [31:0] i_wdata, o_rdata, i_abs_pos, lfsr, rd_v;
  logic signed [15:0] o_speed_ref;
  int n_errors, compares, cyc, n_drain, k, n, a, c;
  int m[11];
  int ks[6] = '{0, 1, 2, 6, 7, 9};
  bit cfg_err;
  axo_axis #(.P_CYC_STEP(20)) axo_axis_i (.i_core_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_lim_pos, .i_lim_neg, .i_prox, .i_phase_z, .i_fb_inc, .i_fb_dec, .i_servo_lock,
    .i_abs_pos, .o_speed_ref, .o_drain, .o_tp_pulse, .o_tp_dir, .o_origin_done, .o_move_ok,
    .o_search_busy);
  axo_drive_model axo_drive_model_i (.i_core_clk, .i_rst, .i_tp_pulse(o_tp_pulse),
    .i_tp_dir(o_tp_dir), .i_flip(flip), .o_fb_inc(i_fb_inc), .o_fb_dec(i_fb_dec));
  //////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    i_core_clk = 1'b0;
    forever #10 i_core_clk = ~i_core_clk;
  end
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      close_out();
    end
  end
  //////////////////////////////////////////////////
  // helpers: random source, compare, bus cycles, model
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] v);
    @(posedge i_core_clk);
    i_wr <= 1'b1;
    i_addr <= ad;
    i_wdata <= v;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
    case (ad >> 2)
      0: if (v >= 1 && v <= axo_pkg::RATE_MAX && v <= m[1]) m[0] = v; else cfg_err = 1;
      1: if (v >= 1 && v <= axo_pkg::RATE_MAX && v >= m[0]) m[1] = v; else cfg_err = 1;
      2: if (v >= 1 && v <= axo_pkg::RPM_MAX) m[2] = v; else cfg_err = 1;
      6: if (v <= axo_pkg::WCHK_TIME_MAX) m[6] = v;
      7: if (v <= axo_pkg::WCHK_PULSES_MAX) m[7] = v;
      9: if (v <= axo_pkg::RPM_MAX) m[9] = v;
      default: ;
    endcase
  endtask
  task automatic rd(input logic [7:0] ad);
    @(posedge i_core_clk);
    i_rd <= 1'b1;
    i_addr <= ad;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1;
    rd_v = o_rdata;
  endtask
  task automatic do_reset();
    i_rst <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    i_rst <= 1'b0;
    m = '{32'h1, 32'h1, 32'hBB8, 32'h26259FF, -32'sh26259FF, 32'h100, 32'hA, 32'h32, 32'h0,
      32'h12C, 32'h1E};
    cfg_err = 0;
    @(posedge i_core_clk);
    #1;
    cmp(o_origin_done, 32'h1, "origin at power on");
    @(posedge i_core_clk);
    #1;
    cmp(o_move_ok, 32'h1, "move allowed");
  endtask
  task automatic run(input int cy);
    repeat (cy) begin
      @(posedge i_core_clk);
      #1;
      if (o_drain === 1'b1) n_drain++;
    end
  endtask
  task automatic wait_busy(input logic v);
    int t;
    t = 0;
    while (o_search_busy !== v && t < 700) begin
      run(1);
      t++;
    end
    cmp(o_search_busy, v, "busy");
  endtask
  task automatic close_out();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  //////////////////////////////////////////////////
  // main sequence
  initial begin
    {i_wr, i_rd, i_lim_pos, i_lim_neg, i_prox, i_phase_z, i_servo_lock, flip} = 8'h0;
    i_addr = 8'h0;
    i_wdata = 32'h0;
    i_abs_pos = 32'h0;
    lfsr = 32'h986BE73A;
    do_reset();
    for (int i = 0; i < 11; i++) begin
      rd(8'(i * 4));
      cmp(rd_v, m[i], "default");
    end
    rd(8'h3C);
    cmp(rd_v, 32'h0, "unmapped");
    // random settings, legal and out of range
    repeat (20) begin
      k = ks[rnd() % 6];
      wr(8'(k * 4), rnd() >> (rnd() % 28));
      rd(8'(k * 4));
      cmp(rd_v, m[k], "setting");
      rd(axo_pkg::A_STATUS);
      cmp(rd_v[5], 32'(cfg_err), "rejected setting");
    end
    // wiring check, good then reversed feedback; unlimited feed wraps position in -2..2
    for (int f = 0; f < 2; f++) begin
      do_reset();
      flip <= f[0];
      n = rnd() % 8 + 1;
      wr(axo_pkg::A_WCHK_PULSES, 32'(n));
      wr(axo_pkg::A_SLIM_NEG, -32'sh2);
      wr(axo_pkg::A_SLIM_POS, 32'h3);
      wr(axo_pkg::A_CFG, 32'h101);
      @(posedge i_core_clk) i_servo_lock <= 1'b1;
      k = 0;
      do begin
        rd(axo_pkg::A_STATUS);
        k++;
      end while (rd_v[4] !== 1'b1 && k < 300);
      cmp(rd_v[4], 32'h1, "check done");
      cmp(rd_v[3], 32'(f), "check error");
      rd(axo_pkg::A_WCHK_COUNT);
      if (f == 0) cmp(rd_v, 32'(n), "feedback count");
      rd(axo_pkg::A_POSITION);
      cmp(rd_v, 32'(((2 + (f ? -n : n)) % 5 + 5) % 5 - 2), "wrapped position");
      @(posedge i_core_clk) i_servo_lock <= 1'b0;
    end
    // reverse mode search, closed-contact proximity; 3000 rpm suits encoders up to 10000 lines
    do_reset();
    wr(axo_pkg::A_SRCH_HI, 32'hBB8);
    wr(axo_pkg::A_CFG, 32'h182);
    @(posedge i_core_clk) i_prox <= 1'b1;
    wr(axo_pkg::A_CTRL, 32'h1);
    wait_busy(1'b1);
    cmp(o_move_ok, 32'h0, "no moves while searching");
    run(3);
    cmp(o_speed_ref, 32'h7FFF, "full speed");
    n_drain = 0;
    @(posedge i_core_clk) i_lim_pos <= 1'b1;
    run(20);
    cmp(32'(n_drain), 32'h1, "drain on limit");
    cmp(o_speed_ref, -32'sh7FFF, "reversed");
    @(posedge i_core_clk) i_lim_pos <= 1'b0;
    @(posedge i_core_clk) i_prox <= 1'b0;
    run(6);
    cmp(o_speed_ref, 32'(m[10] * 32767 / m[2]), "low speed");
    @(posedge i_core_clk) i_phase_z <= 1'b1;
    @(posedge i_core_clk) i_phase_z <= 1'b0;
    wait_busy(1'b0);
    cmp(o_origin_done, 32'h1, "origin found");
    // absolute origin taken on start in power-on mode
    a = rnd() & 32'hFFFF;
    c = rnd() & 32'hFFF;
    @(posedge i_core_clk) i_abs_pos <= 32'(a);
    wr(axo_pkg::A_ABS_CORR, 32'(c));
    wr(axo_pkg::A_CFG, 32'h300);
    wr(axo_pkg::A_CTRL, 32'h1);
    run(3);
    rd(axo_pkg::A_POSITION);
    cmp(rd_v, 32'(a + c), "absolute origin");
    // one-direction mode, each direction pairing and stop method
    for (int i = 0; i < 4; i++) begin
      wr(axo_pkg::A_CFG, 32'h104 + 32'(i * 8) + 32'((i % 2) * 64));
      wr(axo_pkg::A_CTRL, 32'h1);
      wait_busy(1'b1);
      run(3);
      cmp(o_speed_ref, (i == 1 || i == 2) ? -32'sh7FFF : 32'h7FFF, "start dir");
      n_drain = 0;
      @(posedge i_core_clk);
      if (i == 1 || i == 2) i_lim_neg <= 1'b1;
      else i_lim_pos <= 1'b1;
      wait_busy(1'b0);
      cmp(n_drain > 0, i % 2 == 0, "stop method");
      rd(axo_pkg::A_STATUS);
      cmp(rd_v[2], 32'h1, "limit error");
      @(posedge i_core_clk) {i_lim_pos, i_lim_neg} <= 2'h0;
      wr(axo_pkg::A_CTRL, 32'h2);
    end
    close_out();
  end
endmodule
